// [logic/audio_pin_pkg.sv]
// Constants shared by the serial audio pin and clock select block
package audio_pin_pkg;
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 32;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int SYS_PERIOD_PS = 25000;

	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PINFUNC = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_GPIO_DIR = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_GPIO_OUT = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_TXDATA = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_RXDATA = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_DIV = 8'h1c;

	// Control register fields
	localparam int CTL_SYN = 0;
	localparam int CTL_RX_CLOCK_DIRECTION_BIT = 1;
	localparam int CTL_TX_CLOCK_DIRECTION_BIT = 2;
	localparam int CTL_RX_FAST_CLOCK_DIRECTION_BIT = 3;
	localparam int CTL_TX_FAST_CLOCK_DIRECTION_BIT = 4;
	localparam int CTL_RX_FRAME_SYNC_DIRECTION_BIT = 5;
	localparam int CTL_TX_FRAME_SYNC_DIRECTION_BIT = 6;
	localparam int CTL_RX_EXTERNAL_INPUT_SELECT = 7;
	localparam int CTL_TX_EXTERNAL_INPUT_SELECT = 8;
	localparam int CTL_OF0 = 9;
	localparam int CTL_NET = 10;
	localparam int CTL_ONDEM = 11;
	localparam int CTL_TXEN = 12;
	localparam int CTL_RXEN = 13;
	localparam int CTL_DATA_RX = 14;
	localparam int CTRL_W = 15;
	localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;

	// Divider register fields, each holding count minus one
	localparam int DIV_BCLK_LSB = 0;
	localparam int DIV_BCLK_W = 8;
	localparam int DIV_FAST_LSB = 8;
	localparam int DIV_FAST_W = 4;
	localparam int DIV_SLOT_LSB = 12;
	localparam int DIV_SLOT_W = 5;
	localparam int DIV_W = 17;
	localparam logic [DIV_W-1:0] DIV_RST = 17'h00301;

	// Pin indices, shared by pin-function, GPIO and output vectors
	localparam int P_DATA = 0;
	localparam int P_RBCLK = 1;
	localparam int P_TBCLK = 2;
	localparam int P_RFAST = 3;
	localparam int P_TFAST = 4;
	localparam int P_RFS = 5;
	localparam int P_TFS = 6;
	localparam int NPIN = 7;
	localparam int GPIO_W = 3;

	// Synchronised input indices
	localparam int IN_XTAL = 0;
	localparam int IN_DATA = 1;
	localparam int IN_RBCLK = 2;
	localparam int IN_TBCLK = 3;
	localparam int IN_RFAST = 4;
	localparam int IN_TFAST = 5;
	localparam int IN_RFS = 6;
	localparam int IN_TFS = 7;
	localparam int IN_W = 8;

	localparam int ST_W = 7;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SHIFT = 2'b01,
		TX_GAP = 2'b10
	} tx_state_e;
endpackage

// [logic/audio_pin_select.sv]
// Serial audio pin function and bit clock source selection with transmit FIFO
// How it works
// - On-demand with internal clock, data pin floats a full bit period after last bit
// - Shared data pin is input in receive role, output while transmit shifter sends
// - Data and both bit clock pins act as GPIO when their serial function is off
// - Receive bit clock pin direction follows its bit; clock when async, flag when sync
// - As serial flag the receive bit clock pin still follows the direction bit
// - Output flag drives the control bit, updated on the frame sync
// - Input flag captured on frame sync in normal mode, each slot in network mode
// - Async, fast bit zero: receive clock from pin, or from fast pin with pin driven
// - Async, both bits set: receive clock from system or crystal, both pins outputs
// - Async: receive frame sync and fast pins are outputs when their bits are set
// - Transmit bit clock pin direction follows its bit; clocks both sections when sync, transmitter only when async
// - Async, fast bit zero: transmit clock from pin, or from fast pin, pin driven
// - Async, both bits set: transmit clock from system or crystal, both pins outputs
// - Async: transmit frame sync and fast pins are outputs when their bits are set
// - Transmit frame sync serves both sections when sync, transmitter only when async
`timescale 1ns/1ps

module audio_tx_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_s;
	fifo_s s_r;
	fifo_s s_nxt;
	logic push;
	logic pop;

	assign in_ready_o = s_r.cnt != (AW+1)'(DEPTH);
	assign out_valid_o = s_r.cnt != '0;
	assign out_data_o = s_r.mem[s_r.rp];

	always_comb begin
		s_nxt = s_r;
		push = in_valid_i && in_ready_o;
		pop = out_ready_i && out_valid_o;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data_i;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + 1'b1;
		end
		if (push && !pop) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end else if (pop && !push) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

module audio_pin_select #(
	parameter int WORD_W = audio_pin_pkg::WORD_W,
	parameter int FIFO_DEPTH = audio_pin_pkg::FIFO_DEPTH
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic [audio_pin_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [audio_pin_pkg::DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [audio_pin_pkg::DATA_W-1:0] RDATA_O,
	output logic TX_SPACE_O,
	input wire logic CRYSTAL_CLOCK_I,
	input wire logic SHARED_TX5_RX0_DATA_PIN_I,
	output logic SHARED_TX5_RX0_DATA_PIN_O,
	output logic SHARED_TX5_RX0_DATA_PIN_OE_N_O,
	input wire logic RX_BIT_CLOCK_PIN_I,
	output logic RX_BIT_CLOCK_PIN_O,
	output logic RX_BIT_CLOCK_PIN_OE_N_O,
	input wire logic TX_BIT_CLOCK_PIN_I,
	output logic TX_BIT_CLOCK_PIN_O,
	output logic TX_BIT_CLOCK_PIN_OE_N_O,
	input wire logic RX_FAST_CLOCK_PIN_I,
	output logic RX_FAST_CLOCK_PIN_O,
	output logic RX_FAST_CLOCK_PIN_OE_N_O,
	input wire logic TX_FAST_CLOCK_PIN_I,
	output logic TX_FAST_CLOCK_PIN_O,
	output logic TX_FAST_CLOCK_PIN_OE_N_O,
	input wire logic RX_FRAME_SYNC_PIN_I,
	output logic RX_FRAME_SYNC_PIN_O,
	output logic RX_FRAME_SYNC_PIN_OE_N_O,
	input wire logic TX_FRAME_SYNC_PIN_I,
	output logic TX_FRAME_SYNC_PIN_O,
	output logic TX_FRAME_SYNC_PIN_OE_N_O
);
	localparam int BIT_W = $clog2(WORD_W);
	localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(WORD_W-1);

	typedef struct packed {
		logic [audio_pin_pkg::CTRL_W-1:0] ctrl;
		logic [audio_pin_pkg::GPIO_W-1:0] pinfunc;
		logic [audio_pin_pkg::GPIO_W-1:0] gdir;
		logic [audio_pin_pkg::GPIO_W-1:0] gout;
		logic [audio_pin_pkg::DIV_W-1:0] div;
		logic [audio_pin_pkg::DATA_W-1:0] rdata;
		logic tx_space;
		logic [audio_pin_pkg::IN_W-1:0] s1;
		logic [audio_pin_pkg::IN_W-1:0] s2;
		logic [audio_pin_pkg::IN_W-1:0] s3;
		logic [1:0][audio_pin_pkg::DIV_FAST_W-1:0] hf_cnt;
		logic [1:0] hf_out;
		logic [1:0][audio_pin_pkg::DIV_BCLK_W-1:0] bc_cnt;
		logic [1:0] bc_out;
		logic [1:0][BIT_W-1:0] bit_cnt;
		logic [1:0][audio_pin_pkg::DIV_SLOT_W-1:0] slot_cnt;
		logic [1:0] fs_out;
		audio_pin_pkg::tx_state_e tx_state;
		logic [WORD_W-1:0] tx_sh;
		logic [BIT_W-1:0] tx_bits;
		logic rx_run;
		logic [WORD_W-1:0] rx_sh;
		logic [WORD_W-1:0] rx_word;
		logic rx_valid;
		logic if0;
		logic flag_out;
		logic [audio_pin_pkg::NPIN-1:0] pin_o;
		logic [audio_pin_pkg::NPIN-1:0] pin_oe_n;
	} top_s;

	top_s s_r;
	top_s s_nxt;
	logic [audio_pin_pkg::IN_W-1:0] pin_in;
	logic [audio_pin_pkg::IN_W-1:0] in_rise;
	logic [audio_pin_pkg::IN_W-1:0] in_fall;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] slot_evt;
	logic [1:0] frame_evt;
	logic tx_pop;
	logic fifo_push;
	logic fifo_ready;
	logic fifo_valid;
	logic [WORD_W-1:0] fifo_data;

	assign pin_in = {TX_FRAME_SYNC_PIN_I, RX_FRAME_SYNC_PIN_I, TX_FAST_CLOCK_PIN_I, RX_FAST_CLOCK_PIN_I,
		TX_BIT_CLOCK_PIN_I, RX_BIT_CLOCK_PIN_I, SHARED_TX5_RX0_DATA_PIN_I, CRYSTAL_CLOCK_I};
	assign fifo_push = WR_I && (ADDR_I == audio_pin_pkg::ADDR_TXDATA);

	audio_tx_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.in_valid_i(fifo_push),
		.in_ready_o(fifo_ready),
		.in_data_i(WDATA_I[WORD_W-1:0]),
		.out_valid_o(fifo_valid),
		.out_ready_i(tx_pop),
		.out_data_o(fifo_data)
	);

	always_comb begin
		logic ckd;
		logic hckd;
		logic fsd;
		logic ei;
		logic fast_tick;
		logic bit_tick;
		logic fs_in;
		logic last_slot;
		logic syn;
		logic ondem;
		logic start_ok;
		logic r;
		ckd = 1'b0;
		hckd = 1'b0;
		fsd = 1'b0;
		ei = 1'b0;
		fast_tick = 1'b0;
		bit_tick = 1'b0;
		fs_in = 1'b0;
		last_slot = 1'b0;
		start_ok = 1'b0;
		s_nxt = s_r;
		rise = '0;
		fall = '0;
		slot_evt = '0;
		frame_evt = '0;
		tx_pop = 1'b0;
		syn = s_r.ctrl[audio_pin_pkg::CTL_SYN];
		ondem = s_r.ctrl[audio_pin_pkg::CTL_ONDEM];
		r = !syn;
		// Two-stage synchroniser, third stage only for edge detection
		s_nxt.s1 = pin_in;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		in_rise = s_r.s2 & ~s_r.s3;
		in_fall = ~s_r.s2 & s_r.s3;

		// Clock and frame generation, index 0 transmit, 1 receive
		for (int k = 0; k < 2; k++) begin
			ckd = s_r.ctrl[k == 0 ? audio_pin_pkg::CTL_TX_CLOCK_DIRECTION_BIT : audio_pin_pkg::CTL_RX_CLOCK_DIRECTION_BIT];
			hckd = s_r.ctrl[k == 0 ? audio_pin_pkg::CTL_TX_FAST_CLOCK_DIRECTION_BIT : audio_pin_pkg::CTL_RX_FAST_CLOCK_DIRECTION_BIT];
			fsd = s_r.ctrl[k == 0 ? audio_pin_pkg::CTL_TX_FRAME_SYNC_DIRECTION_BIT : audio_pin_pkg::CTL_RX_FRAME_SYNC_DIRECTION_BIT];
			ei = s_r.ctrl[k == 0 ? audio_pin_pkg::CTL_TX_EXTERNAL_INPUT_SELECT : audio_pin_pkg::CTL_RX_EXTERNAL_INPUT_SELECT];
			fast_tick = ei ? in_rise[audio_pin_pkg::IN_XTAL] : 1'b1;
			if (hckd && fast_tick) begin
				if (s_r.hf_cnt[k] == s_r.div[audio_pin_pkg::DIV_FAST_LSB +: audio_pin_pkg::DIV_FAST_W]) begin
					s_nxt.hf_cnt[k] = '0;
					s_nxt.hf_out[k] = !s_r.hf_out[k];
				end else begin
					s_nxt.hf_cnt[k] = s_r.hf_cnt[k] + 1'b1;
				end
			end
			bit_tick = hckd ? fast_tick : in_rise[k == 0 ? audio_pin_pkg::IN_TFAST : audio_pin_pkg::IN_RFAST];
			if (ckd) begin
				if (bit_tick) begin
					if (s_r.bc_cnt[k] == s_r.div[audio_pin_pkg::DIV_BCLK_LSB +: audio_pin_pkg::DIV_BCLK_W]) begin
						s_nxt.bc_cnt[k] = '0;
						s_nxt.bc_out[k] = !s_r.bc_out[k];
						rise[k] = !s_r.bc_out[k];
						fall[k] = s_r.bc_out[k];
					end else begin
						s_nxt.bc_cnt[k] = s_r.bc_cnt[k] + 1'b1;
					end
				end
			end else begin
				// Bit clock taken from its own pin
				s_nxt.bc_cnt[k] = '0;
				s_nxt.bc_out[k] = 1'b0;
				rise[k] = in_rise[k == 0 ? audio_pin_pkg::IN_TBCLK : audio_pin_pkg::IN_RBCLK];
				fall[k] = in_fall[k == 0 ? audio_pin_pkg::IN_TBCLK : audio_pin_pkg::IN_RBCLK];
			end
			fs_in = s_r.s2[k == 0 ? audio_pin_pkg::IN_TFS : audio_pin_pkg::IN_RFS];
			last_slot = !s_r.ctrl[audio_pin_pkg::CTL_NET] ||
				(s_r.slot_cnt[k] == s_r.div[audio_pin_pkg::DIV_SLOT_LSB +: audio_pin_pkg::DIV_SLOT_W]);
			if (rise[k]) begin
				if (!fsd && fs_in) begin
					s_nxt.bit_cnt[k] = '0;
					s_nxt.slot_cnt[k] = '0;
					slot_evt[k] = 1'b1;
					frame_evt[k] = 1'b1;
				end else if (s_r.bit_cnt[k] == LAST_BIT) begin
					s_nxt.bit_cnt[k] = '0;
					s_nxt.slot_cnt[k] = last_slot ? '0 : s_r.slot_cnt[k] + 1'b1;
					slot_evt[k] = 1'b1;
					frame_evt[k] = fsd && last_slot;
				end else begin
					s_nxt.bit_cnt[k] = s_r.bit_cnt[k] + 1'b1;
				end
				s_nxt.fs_out[k] = fsd && frame_evt[k];
			end
		end

		// Register port
		s_nxt.rdata = '0;
		s_nxt.tx_space = fifo_ready;
		if (WR_I) begin
			unique case (ADDR_I)
				audio_pin_pkg::ADDR_CTRL: s_nxt.ctrl = WDATA_I[audio_pin_pkg::CTRL_W-1:0];
				audio_pin_pkg::ADDR_PINFUNC: s_nxt.pinfunc = WDATA_I[audio_pin_pkg::GPIO_W-1:0];
				audio_pin_pkg::ADDR_GPIO_DIR: s_nxt.gdir = WDATA_I[audio_pin_pkg::GPIO_W-1:0];
				audio_pin_pkg::ADDR_GPIO_OUT: s_nxt.gout = WDATA_I[audio_pin_pkg::GPIO_W-1:0];
				audio_pin_pkg::ADDR_DIV: s_nxt.div = WDATA_I[audio_pin_pkg::DIV_W-1:0];
				default: ;
			endcase
		end
		if (RD_I) begin
			unique case (ADDR_I)
				audio_pin_pkg::ADDR_CTRL: s_nxt.rdata = audio_pin_pkg::DATA_W'(s_r.ctrl);
				audio_pin_pkg::ADDR_PINFUNC: s_nxt.rdata = audio_pin_pkg::DATA_W'(s_r.pinfunc);
				audio_pin_pkg::ADDR_GPIO_DIR: s_nxt.rdata = audio_pin_pkg::DATA_W'(s_r.gdir);
				audio_pin_pkg::ADDR_GPIO_OUT: s_nxt.rdata = audio_pin_pkg::DATA_W'(s_r.gout);
				audio_pin_pkg::ADDR_DIV: s_nxt.rdata = audio_pin_pkg::DATA_W'(s_r.div);
				audio_pin_pkg::ADDR_STATUS: s_nxt.rdata = audio_pin_pkg::DATA_W'({s_r.s2[audio_pin_pkg::IN_TBCLK],
					s_r.s2[audio_pin_pkg::IN_RBCLK], s_r.s2[audio_pin_pkg::IN_DATA],
					!fifo_valid, !fifo_ready, s_r.rx_valid, s_r.if0});
				audio_pin_pkg::ADDR_RXDATA: begin
					s_nxt.rdata = audio_pin_pkg::DATA_W'(s_r.rx_word);
					s_nxt.rx_valid = 1'b0;
				end
				default: ;
			endcase
		end

		// Transmit shifter on the shared data pin
		start_ok = s_r.ctrl[audio_pin_pkg::CTL_TXEN] && (ondem ? fifo_valid : slot_evt[0]);
		if (rise[0]) begin
			unique case (s_r.tx_state)
				audio_pin_pkg::TX_IDLE: begin
					if (start_ok) begin
						s_nxt.tx_state = audio_pin_pkg::TX_SHIFT;
					end
				end
				audio_pin_pkg::TX_SHIFT: begin
					if (s_r.tx_bits != '0) begin
						s_nxt.tx_sh = s_r.tx_sh << 1;
						s_nxt.tx_bits = s_r.tx_bits - 1'b1;
					end else if (!start_ok) begin
						s_nxt.tx_state = (ondem && s_r.ctrl[audio_pin_pkg::CTL_TX_CLOCK_DIRECTION_BIT]) ?
							audio_pin_pkg::TX_GAP : audio_pin_pkg::TX_IDLE;
					end
				end
				audio_pin_pkg::TX_GAP: s_nxt.tx_state = audio_pin_pkg::TX_IDLE;
			endcase
			if (start_ok && (s_r.tx_state == audio_pin_pkg::TX_IDLE ||
				(s_r.tx_state == audio_pin_pkg::TX_SHIFT && s_r.tx_bits == '0))) begin
				tx_pop = fifo_valid;
				s_nxt.tx_sh = fifo_valid ? fifo_data : '0;
				s_nxt.tx_bits = LAST_BIT;
			end
		end

		// Receive shifter, on transmit timing in synchronous mode
		if (!s_r.ctrl[audio_pin_pkg::CTL_RXEN] || !s_r.ctrl[audio_pin_pkg::CTL_DATA_RX]) begin
			s_nxt.rx_run = 1'b0;
		end else if (slot_evt[r]) begin
			s_nxt.rx_run = 1'b1;
		end
		if (fall[r] && s_r.rx_run) begin
			s_nxt.rx_sh = {s_r.rx_sh[WORD_W-2:0], s_r.s2[audio_pin_pkg::IN_DATA]};
			if (s_r.bit_cnt[r] == LAST_BIT) begin
				s_nxt.rx_word = {s_r.rx_sh[WORD_W-2:0], s_r.s2[audio_pin_pkg::IN_DATA]};
				s_nxt.rx_valid = 1'b1;
			end
		end

		// Serial flag 0 on the receive bit clock pin
		if (syn && frame_evt[0]) begin
			s_nxt.flag_out = s_r.ctrl[audio_pin_pkg::CTL_OF0];
		end
		if (syn && !s_r.ctrl[audio_pin_pkg::CTL_RX_CLOCK_DIRECTION_BIT] && s_r.pinfunc[audio_pin_pkg::P_RBCLK] &&
			(s_r.ctrl[audio_pin_pkg::CTL_NET] ? slot_evt[0] : frame_evt[0])) begin
			s_nxt.if0 = s_r.s2[audio_pin_pkg::IN_RBCLK];
		end

		// Pin drivers, computed from next state so outputs leave flops
		s_nxt.pin_o = '0;
		s_nxt.pin_oe_n = '1;
		for (int p = 0; p < audio_pin_pkg::GPIO_W; p++) begin
			if (!s_nxt.pinfunc[p] && s_nxt.gdir[p]) begin
				s_nxt.pin_o[p] = s_nxt.gout[p];
				s_nxt.pin_oe_n[p] = 1'b0;
			end
		end
		if (s_nxt.pinfunc[audio_pin_pkg::P_DATA] && !s_nxt.ctrl[audio_pin_pkg::CTL_DATA_RX] &&
			s_nxt.ctrl[audio_pin_pkg::CTL_TXEN] &&
			(!s_nxt.ctrl[audio_pin_pkg::CTL_ONDEM] || s_nxt.tx_state == audio_pin_pkg::TX_SHIFT)) begin
			s_nxt.pin_o[audio_pin_pkg::P_DATA] = s_nxt.tx_sh[WORD_W-1];
			s_nxt.pin_oe_n[audio_pin_pkg::P_DATA] = 1'b0;
		end
		if (s_nxt.pinfunc[audio_pin_pkg::P_RBCLK] && s_nxt.ctrl[audio_pin_pkg::CTL_RX_CLOCK_DIRECTION_BIT]) begin
			s_nxt.pin_o[audio_pin_pkg::P_RBCLK] = s_nxt.ctrl[audio_pin_pkg::CTL_SYN] ?
				s_nxt.flag_out : s_nxt.bc_out[1];
			s_nxt.pin_oe_n[audio_pin_pkg::P_RBCLK] = 1'b0;
		end
		if (s_nxt.pinfunc[audio_pin_pkg::P_TBCLK] && s_nxt.ctrl[audio_pin_pkg::CTL_TX_CLOCK_DIRECTION_BIT]) begin
			s_nxt.pin_o[audio_pin_pkg::P_TBCLK] = s_nxt.bc_out[0];
			s_nxt.pin_oe_n[audio_pin_pkg::P_TBCLK] = 1'b0;
		end
		if (!s_nxt.ctrl[audio_pin_pkg::CTL_SYN] && s_nxt.ctrl[audio_pin_pkg::CTL_RX_FAST_CLOCK_DIRECTION_BIT]) begin
			s_nxt.pin_o[audio_pin_pkg::P_RFAST] = s_nxt.hf_out[1];
			s_nxt.pin_oe_n[audio_pin_pkg::P_RFAST] = 1'b0;
		end
		if (s_nxt.ctrl[audio_pin_pkg::CTL_TX_FAST_CLOCK_DIRECTION_BIT]) begin
			s_nxt.pin_o[audio_pin_pkg::P_TFAST] = s_nxt.hf_out[0];
			s_nxt.pin_oe_n[audio_pin_pkg::P_TFAST] = 1'b0;
		end
		if (!s_nxt.ctrl[audio_pin_pkg::CTL_SYN] && s_nxt.ctrl[audio_pin_pkg::CTL_RX_FRAME_SYNC_DIRECTION_BIT]) begin
			s_nxt.pin_o[audio_pin_pkg::P_RFS] = s_nxt.fs_out[1];
			s_nxt.pin_oe_n[audio_pin_pkg::P_RFS] = 1'b0;
		end
		if (s_nxt.ctrl[audio_pin_pkg::CTL_TX_FRAME_SYNC_DIRECTION_BIT]) begin
			s_nxt.pin_o[audio_pin_pkg::P_TFS] = s_nxt.fs_out[0];
			s_nxt.pin_oe_n[audio_pin_pkg::P_TFS] = 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			s_r <= '0;
			s_r.ctrl <= audio_pin_pkg::CTRL_RST;
			s_r.div <= audio_pin_pkg::DIV_RST;
			s_r.pin_oe_n <= '1;
			// Synchroniser keeps tracking the pins so no false edge follows reset
			s_r.s1 <= s_nxt.s1;
			s_r.s2 <= s_nxt.s2;
			s_r.s3 <= s_nxt.s3;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign RDATA_O = s_r.rdata;
	assign TX_SPACE_O = s_r.tx_space;
	assign SHARED_TX5_RX0_DATA_PIN_O = s_r.pin_o[audio_pin_pkg::P_DATA];
	assign SHARED_TX5_RX0_DATA_PIN_OE_N_O = s_r.pin_oe_n[audio_pin_pkg::P_DATA];
	assign RX_BIT_CLOCK_PIN_O = s_r.pin_o[audio_pin_pkg::P_RBCLK];
	assign RX_BIT_CLOCK_PIN_OE_N_O = s_r.pin_oe_n[audio_pin_pkg::P_RBCLK];
	assign TX_BIT_CLOCK_PIN_O = s_r.pin_o[audio_pin_pkg::P_TBCLK];
	assign TX_BIT_CLOCK_PIN_OE_N_O = s_r.pin_oe_n[audio_pin_pkg::P_TBCLK];
	assign RX_FAST_CLOCK_PIN_O = s_r.pin_o[audio_pin_pkg::P_RFAST];
	assign RX_FAST_CLOCK_PIN_OE_N_O = s_r.pin_oe_n[audio_pin_pkg::P_RFAST];
	assign TX_FAST_CLOCK_PIN_O = s_r.pin_o[audio_pin_pkg::P_TFAST];
	assign TX_FAST_CLOCK_PIN_OE_N_O = s_r.pin_oe_n[audio_pin_pkg::P_TFAST];
	assign RX_FRAME_SYNC_PIN_O = s_r.pin_o[audio_pin_pkg::P_RFS];
	assign RX_FRAME_SYNC_PIN_OE_N_O = s_r.pin_oe_n[audio_pin_pkg::P_RFS];
	assign TX_FRAME_SYNC_PIN_O = s_r.pin_o[audio_pin_pkg::P_TFS];
	assign TX_FRAME_SYNC_PIN_OE_N_O = s_r.pin_oe_n[audio_pin_pkg::P_TFS];

	// Checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	a_gap_floats: assert property ($rose(s_r.tx_state == audio_pin_pkg::TX_GAP) |->
		SHARED_TX5_RX0_DATA_PIN_OE_N_O [*2]) else $error("data pin driven during on-demand gap");
	a_rx_role_input: assert property (s_r.ctrl[audio_pin_pkg::CTL_DATA_RX] && s_r.pinfunc[audio_pin_pkg::P_DATA] |->
		SHARED_TX5_RX0_DATA_PIN_OE_N_O) else $error("data pin driven in receive role");
	a_gpio_drive: assert property (!s_r.pinfunc[audio_pin_pkg::P_TBCLK] && s_r.gdir[audio_pin_pkg::P_TBCLK] |->
		!TX_BIT_CLOCK_PIN_OE_N_O && TX_BIT_CLOCK_PIN_O == s_r.gout[audio_pin_pkg::P_TBCLK])
		else $error("bit clock pin not acting as GPIO");
	a_rbclk_clock: assert property (!s_r.ctrl[audio_pin_pkg::CTL_SYN] && s_r.pinfunc[audio_pin_pkg::P_RBCLK] &&
		s_r.ctrl[audio_pin_pkg::CTL_RX_CLOCK_DIRECTION_BIT] |-> RX_BIT_CLOCK_PIN_O == s_r.bc_out[1])
		else $error("receive bit clock pin not driving clock");
	a_flag_dir: assert property (s_r.ctrl[audio_pin_pkg::CTL_SYN] && s_r.pinfunc[audio_pin_pkg::P_RBCLK] |->
		RX_BIT_CLOCK_PIN_OE_N_O == !s_r.ctrl[audio_pin_pkg::CTL_RX_CLOCK_DIRECTION_BIT]) else $error("flag pin direction wrong");
	a_flag_out: assert property (s_r.ctrl[audio_pin_pkg::CTL_SYN] && frame_evt[0] |=>
		s_r.flag_out == $past(s_r.ctrl[audio_pin_pkg::CTL_OF0])) else $error("output flag not updated on frame");
	a_flag_in: assert property (s_r.ctrl[audio_pin_pkg::CTL_SYN] && !s_r.ctrl[audio_pin_pkg::CTL_RX_CLOCK_DIRECTION_BIT] &&
		s_r.pinfunc[audio_pin_pkg::P_RBCLK] && !s_r.ctrl[audio_pin_pkg::CTL_NET] && frame_evt[0] |=>
		s_r.if0 == $past(s_r.s2[audio_pin_pkg::IN_RBCLK])) else $error("input flag not captured");
	a_fast_src: assert property (!s_r.ctrl[audio_pin_pkg::CTL_SYN] && !s_r.ctrl[audio_pin_pkg::CTL_RX_FAST_CLOCK_DIRECTION_BIT] |->
		RX_FAST_CLOCK_PIN_OE_N_O) else $error("receive fast pin driven while input");
	a_xtal_src: assert property (s_r.ctrl[audio_pin_pkg::CTL_RX_FAST_CLOCK_DIRECTION_BIT] && s_r.ctrl[audio_pin_pkg::CTL_RX_CLOCK_DIRECTION_BIT] &&
		s_r.ctrl[audio_pin_pkg::CTL_RX_EXTERNAL_INPUT_SELECT] && !in_rise[audio_pin_pkg::IN_XTAL] && $stable(s_r.ctrl) |=>
		$stable(s_r.bc_cnt[1]) && $stable(s_r.bc_out[1])) else $error("receive clock moved without crystal edge");
	a_rfs_out: assert property (!s_r.ctrl[audio_pin_pkg::CTL_SYN] && s_r.ctrl[audio_pin_pkg::CTL_RX_FRAME_SYNC_DIRECTION_BIT] |->
		!RX_FRAME_SYNC_PIN_OE_N_O && RX_FRAME_SYNC_PIN_O == s_r.fs_out[1]) else $error("receive frame sync not output");
	a_tbclk_dir: assert property (s_r.pinfunc[audio_pin_pkg::P_TBCLK] |->
		TX_BIT_CLOCK_PIN_OE_N_O == !s_r.ctrl[audio_pin_pkg::CTL_TX_CLOCK_DIRECTION_BIT]) else $error("transmit clock pin direction wrong");
	a_tfast_src: assert property (!s_r.ctrl[audio_pin_pkg::CTL_TX_FAST_CLOCK_DIRECTION_BIT] && s_r.ctrl[audio_pin_pkg::CTL_TX_CLOCK_DIRECTION_BIT] &&
		!in_rise[audio_pin_pkg::IN_TFAST] && $stable(s_r.ctrl) |=> $stable(s_r.bc_out[0]))
		else $error("transmit clock moved without fast pin edge");
	a_tclk_outputs: assert property (s_r.ctrl[audio_pin_pkg::CTL_TX_FAST_CLOCK_DIRECTION_BIT] && s_r.ctrl[audio_pin_pkg::CTL_TX_CLOCK_DIRECTION_BIT] &&
		s_r.pinfunc[audio_pin_pkg::P_TBCLK] |-> !TX_FAST_CLOCK_PIN_OE_N_O && !TX_BIT_CLOCK_PIN_OE_N_O)
		else $error("transmit clock pins not outputs");
	a_tfs_out: assert property (s_r.ctrl[audio_pin_pkg::CTL_TX_FRAME_SYNC_DIRECTION_BIT] |->
		!TX_FRAME_SYNC_PIN_OE_N_O) else $error("transmit frame sync not output");
	a_sync_rx: assert property (s_r.ctrl[audio_pin_pkg::CTL_SYN] && slot_evt[0] && s_r.ctrl[audio_pin_pkg::CTL_RXEN] &&
		s_r.ctrl[audio_pin_pkg::CTL_DATA_RX] && $stable(s_r.ctrl) |=> s_r.rx_run) else $error("receiver ignores transmit sync");
	a_sync_edge: assert property (!s_r.ctrl[audio_pin_pkg::CTL_SYN] && !s_r.ctrl[audio_pin_pkg::CTL_RX_CLOCK_DIRECTION_BIT] && rise[1] |->
		$past(RX_BIT_CLOCK_PIN_I, 2) && !$past(RX_BIT_CLOCK_PIN_I, 3)) else $error("edge not from synchronised pin");

	c_gap: cover property ($rose(s_r.tx_state == audio_pin_pkg::TX_GAP));
	c_rx_word: cover property ($rose(s_r.rx_valid));
	c_back_to_back: cover property (rise[0] && s_r.tx_state == audio_pin_pkg::TX_SHIFT && s_r.tx_bits == '0 && tx_pop);
endmodule

// [bench/audio_partner.sv]
// Far-side codec model: free bit clock and data line pattern
`timescale 1ns/1ps
module audio_partner (
	input wire logic data_oe_n_i,
	input wire logic data_i,
	output logic bclk_o = 1'b0,
	output logic data_o = 1'b0
);
	always #100 bclk_o = ~bclk_o;
	always @(posedge bclk_o) data_o <= data_oe_n_i ? ~data_o : data_i;
endmodule

// [bench/testbench.sv]
// Self-checking bench for the audio pin and clock select block
`timescale 1ns/1ps
module testbench;
	logic CLK_I = 1'b0, RESET_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0, flag_in = 1'b0;
	logic TX_SPACE_O, bclk, far_d, d_line, b, xtal = 1'b0;
	logic [7:0] ADDR_I = 8'h00;
	logic [31:0] WDATA_I = 32'h0, RDATA_O, r;
	wire [6:0] po, pe;
	logic [15:0] words [33];
	logic [14:0] c;
	int bad_count = 0, n_tests = 0;
	assign d_line = pe[0] ? far_d : po[0];
	audio_partner u_audio_partner (.data_oe_n_i(pe[0]), .data_i(po[0]), .bclk_o(bclk), .data_o(far_d));
	audio_pin_select u_audio_pin_select (.CLK_I, .RESET_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .TX_SPACE_O,
		.CRYSTAL_CLOCK_I(xtal), .SHARED_TX5_RX0_DATA_PIN_I(d_line), .SHARED_TX5_RX0_DATA_PIN_O(po[0]),
		.SHARED_TX5_RX0_DATA_PIN_OE_N_O(pe[0]), .RX_BIT_CLOCK_PIN_I(pe[1] ? flag_in : po[1]),
		.RX_BIT_CLOCK_PIN_O(po[1]), .RX_BIT_CLOCK_PIN_OE_N_O(pe[1]), .TX_BIT_CLOCK_PIN_I(pe[2] ? bclk : po[2]),
		.TX_BIT_CLOCK_PIN_O(po[2]), .TX_BIT_CLOCK_PIN_OE_N_O(pe[2]), .RX_FAST_CLOCK_PIN_I(pe[3] ? xtal : po[3]),
		.RX_FAST_CLOCK_PIN_O(po[3]), .RX_FAST_CLOCK_PIN_OE_N_O(pe[3]), .TX_FAST_CLOCK_PIN_I(pe[4] ? xtal : po[4]),
		.TX_FAST_CLOCK_PIN_O(po[4]), .TX_FAST_CLOCK_PIN_OE_N_O(pe[4]), .RX_FRAME_SYNC_PIN_I(1'b0),
		.RX_FRAME_SYNC_PIN_O(po[5]), .RX_FRAME_SYNC_PIN_OE_N_O(pe[5]), .TX_FRAME_SYNC_PIN_I(1'b0),
		.TX_FRAME_SYNC_PIN_O(po[6]), .TX_FRAME_SYNC_PIN_OE_N_O(pe[6]));
	initial begin
		forever #12.5 CLK_I = ~CLK_I;
	end
	initial begin
		forever #60 xtal = ~xtal;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge CLK_I);
		WR_I <= 1'b0;
		@(posedge CLK_I);
	endtask
	task automatic rd(input logic [7:0] a);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		@(posedge CLK_I);
		r = RDATA_O;
	endtask
	task automatic tally_and_finish();
		$display("tests %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#500000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(12442));
		repeat (2) @(posedge CLK_I);
		RESET_I <= 1'b0;
		@(posedge CLK_I);
		chk({25'h0, pe}, 32'h7f);
		rd(audio_pin_pkg::ADDR_DIV);
		chk(r, 32'h301);
		rd(8'h20);
		chk(r, 32'h0);
		c = 15'($urandom);
		wr(audio_pin_pkg::ADDR_GPIO_DIR, 32'h7);
		wr(audio_pin_pkg::ADDR_GPIO_OUT, {17'h0, c});
		chk({26'h0, po[2:0], pe[2:0]}, {26'h0, c[2:0], 3'h0});
		repeat (2) @(posedge CLK_I);
		rd(audio_pin_pkg::ADDR_STATUS);
		chk({29'h0, r[6:4]}, {29'h0, c[2:0]});
		wr(audio_pin_pkg::ADDR_PINFUNC, 32'h7);
		for (int i = 0; i < 8; i++) begin
			c = (i == 0) ? 15'h1ff : 15'($urandom) & 15'h1ff;
			wr(audio_pin_pkg::ADDR_CTRL, {17'h0, c});
			chk({26'h0, pe[6:1]}, {26'h0, ~c[6], ~c[5] | c[0], ~c[4], ~c[3] | c[0], ~c[2:1]});
		end
		for (int j = 0; j < 2; j++) begin
			wr(audio_pin_pkg::ADDR_CTRL, j ? 32'h114 : 32'h4);
			b = po[2];
			for (int k = 0; k < 40 && po[2] === b; k++)
				@(posedge CLK_I);
			chk({31'h0, po[2] !== b}, 32'h1);
		end
		wr(audio_pin_pkg::ADDR_CTRL, 32'h1257);
		for (int k = 0; k < 200 && po[1] !== 1'b1; k++)
			@(posedge CLK_I);
		chk({31'h0, po[1]}, 32'h1);
		wr(audio_pin_pkg::ADDR_CTRL, 32'h1055);
		flag_in <= 1'b1;
		repeat (200) @(posedge CLK_I);
		rd(audio_pin_pkg::ADDR_STATUS);
		chk({31'h0, r[0]}, 32'h1);
		wr(audio_pin_pkg::ADDR_CTRL, 32'h6041);
		repeat (400) @(posedge CLK_I);
		chk({31'h0, pe[0]}, 32'h1);
		rd(audio_pin_pkg::ADDR_STATUS);
		chk({31'h0, r[1]}, 32'h1);
		rd(audio_pin_pkg::ADDR_RXDATA);
		chk({31'h0, r[15:0] == 16'haaaa || r[15:0] == 16'h5555}, 32'h1);
		wr(audio_pin_pkg::ADDR_CTRL, 32'h0);
		for (int i = 0; i < 33; i++) begin
			words[i] = 16'($urandom);
			wr(audio_pin_pkg::ADDR_TXDATA, {16'h0, words[i]});
		end
		rd(audio_pin_pkg::ADDR_STATUS);
		chk({29'h0, TX_SPACE_O, r[3:2]}, 32'h1);
		wr(audio_pin_pkg::ADDR_CTRL, 32'h1814);
		for (int k = 0; k < 100 && pe[0] !== 1'b0; k++)
			@(posedge CLK_I);
		repeat (2) @(posedge CLK_I);
		for (int i = 0; i < 512; i++) begin
			chk({30'h0, pe[0], po[0]}, {31'h0, words[i / 16][15 - i % 16]});
			repeat (4) @(posedge CLK_I);
		end
		chk({31'h0, pe[0]}, 32'h1);
		tally_and_finish();
	end
endmodule
